/* File: bench/wls_load.sv */
// Load model standing at the supply output: reads back voltage and current.
// Assumes a setpoint and an output enable from the sequencer core.
`timescale 1ns/1ps
`default_nettype none
module wls_load
    import wls_pkg::*;
(
    input wire logic [VW-1:0] setpoint_i,
    input wire logic out_en_i,
    output logic [VW-1:0] meas_v_o,
    output logic [VW-1:0] meas_i_o
);
    // Resistive load of four units; a disabled output reads zero
    assign meas_v_o = out_en_i ? setpoint_i : '0;
    assign meas_i_o = out_en_i ? (setpoint_i >> 2) : '0;
endmodule
`default_nettype wire

/* File: bench/wls_tb.sv */
// Self-checking bench of the sequencer core over its register port.
// Assumes one dwell tick of 1000 cycles and a 3-cycle step between points.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
    import wls_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0, btrig = 1'b0;
    logic [7:0] addr = '0;
    logic [31:0] wdata = '0, rdata, d;
    logic [VW-1:0] setp, mv, mi;
    logic out_en, mode_curr, run, trig;
    int errors = 0, checks_done = 0, ntrig = 0;
    wls_core wls_core_inst (.CLK_I(clk), .RESETN_I(rstn), .CE_I(ce), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .BUS_TRIG_I(btrig), .MEAS_V_I(mv), .MEAS_I_I(mi), .RDATA_O(rdata),
        .SETPOINT_O(setp), .OUT_EN_O(out_en), .MODE_CURR_O(mode_curr), .LIST_RUN_O(run), .TRIG_O(trig));
    wls_load wls_load_inst (.setpoint_i(setp), .out_en_i(out_en), .meas_v_o(mv), .meas_i_o(mi));
    // Clock and count of accepted trigger pulses
    always #5 clk = ~clk;
    always @(posedge clk) if (trig === 1'b1) ntrig <= ntrig + 1;
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= v;
        @(posedge clk); wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cmd(input logic [3:0] c);
        wreg(REG_CMD, {28'h0, c});
    endtask
    task automatic btrig_pulse();
        @(posedge clk); btrig <= 1'b1;
        @(posedge clk); btrig <= 1'b0;
    endtask
    // Start a list and sample each point in the middle of its dwell
    task automatic play(input logic [3:0] c, input int n, input logic [15:0] ex [8]);
        cmd(c);
        #1 `CHK(run, 1'b1)
        repeat (503) @(posedge clk);
        for (int k = 0; k < n; k++) begin
            #1 `CHK(setp, ex[k])
            repeat (1003) @(posedge clk);
        end
        #1 `CHK(run, 1'b0)
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog: the tests need about 17000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        errors++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        rreg(REG_STATUS); `CHK(d, 32'h0)
        rreg(REG_POINTS); `CHK(d, 32'h0)
        btrig_pulse(); cmd(CMD_TRG); repeat (3) @(posedge clk);
        `CHK(ntrig, 0)
        cmd(CMD_ARM); btrig_pulse(); btrig_pulse(); cmd(CMD_ARM); cmd(CMD_TRG); repeat (3) @(posedge clk);
        `CHK(ntrig, 2)
        $display("test trigger done");
        cmd(CMD_CLEAR);
        for (int k = 1; k < 4; k++) begin
            wreg(REG_DATA, 32'h11 * k); cmd(CMD_ADD_V);
        end
        wreg(REG_DATA, 32'h1); cmd(CMD_ADD_DWELL);
        cmd(CMD_ADD_C);
        rreg(REG_STATUS); `CHK(d[ST_REJ], 1'b1)
        rreg(REG_POINTS); `CHK(d, 32'h3)
        wreg(REG_STATUS, 32'hC0);
        wreg(REG_COUNT, 32'h1); wreg(REG_CFG, 32'h1);
        play(CMD_VLIST, 3, '{0: 16'h33, 1: 16'h22, 2: 16'h11, default: 16'h0});
        wreg(REG_CFG, 32'h0); wreg(REG_COUNT, 32'h2); wreg(REG_SKIP, 32'h1);
        play(CMD_VLIST, 5, '{0: 16'h11, 1: 16'h22, 2: 16'h33, 3: 16'h22, 4: 16'h33, default: 16'h0});
        wreg(REG_DATA, 32'h44); cmd(CMD_ADD_V);
        rreg(REG_POINTS); `CHK(d, 32'h4)
        $display("test playback done");
        // Endless run: second pass restarts at point 1 as set in REG_SKIP
        wreg(REG_COUNT, 32'h0); cmd(CMD_VLIST); repeat (4100) @(posedge clk);
        #1 `CHK(run, 1'b1)
        wreg(REG_SKIP, 32'h0);
        rreg(REG_STATUS); `CHK(d[ST_REJ], 1'b1)
        cmd(CMD_FIX);
        #1 `CHK(run, 1'b0)
        `CHK(setp, 16'h0022)
        rreg(REG_SETPT); `CHK(d, 32'h22)
        cmd(CMD_FUNC_C); wreg(REG_DATA, 32'h100); cmd(CMD_LEVEL); cmd(CMD_OUT_ON);
        #1 `CHK(out_en, 1'b1)
        `CHK(mode_curr, 1'b1)
        rreg(REG_MEAS); `CHK(d, 32'h0040_0100)
        cmd(CMD_RST);
        #1 `CHK({out_en, mode_curr, run}, 3'b000)
        $display("test stop done");
        // Index sequence 3,0,3 over the four stored points; index 4 is past the end
        wreg(REG_STATUS, 32'h40); wreg(REG_CFG, 32'h2); wreg(REG_COUNT, 32'h1);
        wreg(REG_DATA, 32'h3); cmd(CMD_ADD_SEQ);
        wreg(REG_DATA, 32'h0); cmd(CMD_ADD_SEQ);
        wreg(REG_DATA, 32'h3); cmd(CMD_ADD_SEQ);
        wreg(REG_DATA, 32'h4); cmd(CMD_ADD_SEQ);
        rreg(REG_STATUS); `CHK(d[ST_REJ], 1'b1)
        play(CMD_VLIST, 3, '{0: 16'h44, 1: 16'h11, 2: 16'h44, default: 16'h0});
        $display("test sequence done");
        wreg(REG_CHAR, 32'h2A); wreg(REG_CHAR, 32'h58); wreg(REG_CHAR, {24'h0, CH_CR});
        rreg(REG_STATUS); `CHK(d[ST_COMMON:ST_MSG], 2'b11)
        wreg(REG_STATUS, 32'h80); wreg(REG_CHAR, {24'h0, CH_LF});
        rreg(REG_STATUS); `CHK(d[ST_MSG], 1'b0)
        wreg(REG_CHAR, 32'h56); wreg(REG_CHAR, {24'h0, CH_LF});
        rreg(REG_STATUS); `CHK(d[ST_COMMON:ST_MSG], 2'b01)
        $display("test message done");
        summarize();
    end
endmodule
`default_nettype wire

/* File: rtl/wls_core.sv */
// Waveform list sequencer core: register port, list storage, playback and
// a small character front end for message framing.
// Assumes one 100 MHz clock; all inputs are synchronous to it.
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module wls_core
    import wls_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    input wire logic BUS_TRIG_I,
    input wire logic [VW-1:0] MEAS_V_I,
    input wire logic [VW-1:0] MEAS_I_I,
    output logic [31:0] RDATA_O,
    output logic [VW-1:0] SETPOINT_O,
    output logic OUT_EN_O,
    output logic MODE_CURR_O,
    output logic LIST_RUN_O,
    output logic TRIG_O
);
    wls_state_s s;
    wls_state_s n;
    logic pt_we;
    logic dw_we;
    logic sq_we;
    logic [AW-1:0] pt_addr;
    logic [AW-1:0] dw_addr;
    logic [AW-1:0] sq_addr;
    logic [VW-1:0] pt_rdata;
    logic [VW-1:0] dw_rdata;
    logic [AW-1:0] sq_rdata;
    logic [CW-1:0] len;
    logic [CW-1:0] pos_eff;
    logic [CW-1:0] wrap_pos;
    logic cfg_wr;
    logic trig_req;
    logic tick_end;
    logic last_pt;

    // Setpoints, dwells and index sequence live in three list memories
    wls_mem #(.DEPTH(MAX_PTS), .AW(AW), .DW(VW)) u_pt (
        .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ce_i(CE_I), .we_i(pt_we),
        .addr_i(pt_addr), .wdata_i(s.data), .rdata_o(pt_rdata)
    );
    wls_mem #(.DEPTH(MAX_PTS), .AW(AW), .DW(VW)) u_dw (
        .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ce_i(CE_I), .we_i(dw_we),
        .addr_i(dw_addr), .wdata_i(s.data), .rdata_o(dw_rdata)
    );
    wls_mem #(.DEPTH(MAX_PTS), .AW(AW), .DW(AW)) u_sq (
        .CLK_I(CLK_I), .RESETN_I(RESETN_I), .ce_i(CE_I), .we_i(sq_we),
        .addr_i(sq_addr), .wdata_i(s.data[AW-1:0]), .rdata_o(sq_rdata)
    );

    // Playback geometry: length, effective position and restart point
    always_comb begin
        len = s.gen_seq ? s.nseq : s.npts;
        pos_eff = s.dir_down ? CW'(len - s.pos - CW'(1)) : s.pos;
        wrap_pos = (s.skip < len) ? s.skip : '0;
        tick_end = (s.tick_cnt == TICK_LAST);
        last_pt = (CW'(s.pos + CW'(1)) >= len);
        cfg_wr = WR_I && (ADDR_I == REG_COUNT || ADDR_I == REG_SKIP || ADDR_I == REG_CFG);
        trig_req = BUS_TRIG_I || (WR_I && ADDR_I == REG_CMD && WDATA_I[3:0] == CMD_TRG);
    end

    // Memory ports: playback owns them while running, appends otherwise
    always_comb begin
        sq_addr = (s.phase == PH_SEQ) ? pos_eff[AW-1:0] : s.nseq[AW-1:0];
        pt_addr = s.npts[AW-1:0];
        dw_addr = s.ndwell[AW-1:0];
        if (s.phase == PH_PT) begin
            pt_addr = s.gen_seq ? sq_rdata : pos_eff[AW-1:0];
            dw_addr = pt_addr;
        end
        pt_we = 1'b0;
        dw_we = 1'b0;
        sq_we = 1'b0;
        if (WR_I && ADDR_I == REG_CMD && !s.running) begin
            if ((WDATA_I[3:0] == CMD_ADD_V && !(s.kind_set && s.kind_curr)) ||
                (WDATA_I[3:0] == CMD_ADD_C && !(s.kind_set && !s.kind_curr))) begin
                pt_we = (s.npts < MAX_PTS_C);
            end
            dw_we = (WDATA_I[3:0] == CMD_ADD_DWELL) && (s.ndwell < MAX_PTS_C);
            sq_we = (WDATA_I[3:0] == CMD_ADD_SEQ) && (s.nseq < MAX_PTS_C) &&
                    (CW'(s.data[AW-1:0]) < s.npts);
        end
    end

    // Next-state logic: playback first, then bus traffic overrides it
    always_comb begin
        n = s;
        n.trig = 1'b0;
        n.rdata = '0;
        case (s.phase)
            PH_IDLE: begin
            end
            PH_SEQ: n.phase = PH_PT;
            PH_PT: n.phase = PH_LOAD;
            PH_LOAD: begin
                n.setpoint = pt_rdata;
                n.dwell_left = (s.ndwell > CW'(1)) ? dw_rdata : s.dwell_one;
                n.tick_cnt = '0;
                n.phase = PH_DWELL;
            end
            PH_DWELL: begin
                n.tick_cnt = tick_end ? '0 : 16'(s.tick_cnt + 16'h0001);
                if (tick_end) begin
                    if (s.dwell_left > VW'(1)) begin
                        n.dwell_left = VW'(s.dwell_left - VW'(1));
                    end else if (!last_pt) begin
                        n.pos = CW'(s.pos + CW'(1));
                        n.phase = PH_SEQ;
                    end else if (s.count == 8'h00) begin
                        n.pos = wrap_pos;
                        n.phase = PH_SEQ;
                    end else if (s.left <= 8'h01) begin
                        n.running = 1'b0;
                        n.phase = PH_IDLE;
                    end else begin
                        n.left = 8'(s.left - 8'h01);
                        n.pos = wrap_pos;
                        n.phase = PH_SEQ;
                    end
                end
            end
            default: n.phase = PH_IDLE;
        endcase
        // Triggers only count while armed; one accepted trigger disarms
        if (trig_req && s.armed) begin
            n.trig = 1'b1;
            n.armed = 1'b0;
        end
        // Configuration is refused while a list plays
        if (cfg_wr && s.running) begin
            n.rejected = 1'b1;
        end else if (WR_I) begin
            case (ADDR_I)
                REG_DATA: n.data = WDATA_I[VW-1:0];
                REG_COUNT: begin
                    n.count = WDATA_I[7:0];
                end
                REG_SKIP: n.skip = WDATA_I[CW-1:0];
                REG_CFG: begin
                    n.dir_down = WDATA_I[CFG_DIR];
                    n.gen_seq = WDATA_I[CFG_GEN];
                end
                REG_STATUS: begin
                    if (WDATA_I[ST_REJ]) begin
                        n.rejected = 1'b0;
                    end
                    if (WDATA_I[ST_MSG]) begin
                        n.msg_done = 1'b0;
                    end
                end
                REG_CHAR: begin
                    if (WDATA_I[7:0] == CH_LF && s.prev_cr) begin
                        n.prev_cr = 1'b0;
                    end else if (WDATA_I[7:0] == CH_LF || WDATA_I[7:0] == CH_CR) begin
                        n.msg_done = 1'b1;
                        n.msg_common = s.common_now;
                        n.at_start = 1'b1;
                        n.prev_cr = (WDATA_I[7:0] == CH_CR);
                    end else begin
                        n.prev_cr = 1'b0;
                        n.at_start = (WDATA_I[7:0] == CH_SEMI);
                        if (s.at_start) begin
                            n.common_now = (WDATA_I[7:0] == CH_STAR);
                        end
                    end
                end
                REG_CMD: begin
                    case (WDATA_I[3:0])
                        CMD_ARM: n.armed = 1'b1;
                        CMD_TRG: begin
                        end
                        CMD_RST: begin
                            n.running = 1'b0;
                            n.phase = PH_IDLE;
                            n.out_on = 1'b0;
                            n.mode_curr = 1'b0;
                            n.armed = 1'b0;
                        end
                        CMD_FIX: begin
                            n.running = 1'b0;
                            n.phase = PH_IDLE;
                            n.setpoint = s.setpoint;
                        end
                        CMD_VLIST, CMD_CLIST: begin
                            if (!s.running && len != '0) begin
                                n.running = 1'b1;
                                n.mode_curr = (WDATA_I[3:0] == CMD_CLIST);
                                n.pos = '0;
                                n.left = s.count;
                                n.phase = PH_SEQ;
                            end
                        end
                        CMD_OUT_ON: n.out_on = 1'b1;
                        CMD_OUT_OFF: n.out_on = 1'b0;
                        CMD_FUNC_V: n.mode_curr = 1'b0;
                        CMD_FUNC_C: n.mode_curr = 1'b1;
                        CMD_LEVEL: begin
                            if (!s.running) begin
                                n.setpoint = s.data;
                            end
                        end
                        default: begin
                            if (s.running) begin
                                n.rejected = 1'b1;
                            end else if (WDATA_I[3:0] == CMD_CLEAR) begin
                                n.npts = '0;
                                n.ndwell = '0;
                                n.nseq = '0;
                                n.kind_set = 1'b0;
                            end else if (WDATA_I[3:0] == CMD_ADD_DWELL) begin
                                n.ndwell = dw_we ? CW'(s.ndwell + CW'(1)) : s.ndwell;
                                n.dwell_one = (s.ndwell == '0) ? s.data : s.dwell_one;
                                n.rejected = !dw_we;
                            end else if (WDATA_I[3:0] == CMD_ADD_SEQ) begin
                                n.nseq = sq_we ? CW'(s.nseq + CW'(1)) : s.nseq;
                                n.rejected = !sq_we;
                            end else begin
                                n.npts = pt_we ? CW'(s.npts + CW'(1)) : s.npts;
                                n.kind_set = s.kind_set || pt_we;
                                n.kind_curr = pt_we ? (WDATA_I[3:0] == CMD_ADD_C) : s.kind_curr;
                                n.rejected = !pt_we;
                            end
                        end
                    endcase
                end
                default: begin
                end
            endcase
        end
        // Read data stand only in the cycle after the strobe
        if (RD_I) begin
            case (ADDR_I)
                REG_DATA: n.rdata = 32'(s.data);
                REG_COUNT: n.rdata = 32'(s.count);
                REG_SKIP: n.rdata = 32'(s.skip);
                REG_CFG: n.rdata = 32'({s.gen_seq, s.dir_down});
                REG_STATUS: n.rdata = 32'({s.gen_seq, s.dir_down, s.msg_common, s.msg_done,
                                          s.rejected, s.kind_curr, s.kind_set, s.mode_curr,
                                          s.out_on, s.armed, s.running});
                REG_POINTS: n.rdata = 32'(s.npts);
                REG_MEAS: n.rdata = {MEAS_I_I, MEAS_V_I};
                REG_SETPT: n.rdata = 32'(s.setpoint);
                default: n.rdata = '0;
            endcase
        end
    end

    // State register; clock enable freezes everything
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            s <= '{phase: PH_IDLE, at_start: 1'b1, default: '0};
        end else if (CE_I) begin
            s <= n;
        end
    end

    // All outputs come straight from the state register
    assign RDATA_O = s.rdata;
    assign SETPOINT_O = s.setpoint;
    assign OUT_EN_O = s.out_on;
    assign MODE_CURR_O = s.mode_curr;
    assign LIST_RUN_O = s.running;
    assign TRIG_O = s.trig;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);

    sequence s_cmd(logic [3:0] c);
        CE_I && WR_I && ADDR_I == REG_CMD && WDATA_I[3:0] == c;
    endsequence
    sequence s_pass_end;
        CE_I && s.phase == PH_DWELL && tick_end && s.dwell_left <= VW'(1) && last_pt && !WR_I;
    endsequence

    property p_trig_drop;
        CE_I && trig_req && !s.armed |=> !TRIG_O;
    endproperty
    a_trig_drop: assert property (p_trig_drop) else $error("trigger taken while disarmed");
    property p_trig_take;
        CE_I && trig_req && s.armed && !(WR_I && ADDR_I == REG_CMD && WDATA_I[3:0] == CMD_ARM) |=> TRIG_O && !s.armed;
    endproperty
    a_trig_take: assert property (p_trig_take) else $error("armed trigger lost");
    property p_cfg_reject;
        CE_I && cfg_wr && s.running |=> s.rejected && $stable(s.count) && $stable(s.skip);
    endproperty
    a_cfg_reject: assert property (p_cfg_reject) else $error("config accepted while running");
    property p_mix;
        s_cmd(CMD_ADD_V) and (s.kind_set && s.kind_curr && !s.running) |=> s.rejected && $stable(s.npts);
    endproperty
    a_mix: assert property (p_mix) else $error("voltage point mixed into current list");
    property p_rst;
        s_cmd(CMD_RST) |=> !OUT_EN_O && !LIST_RUN_O && !MODE_CURR_O;
    endproperty
    a_rst: assert property (p_rst) else $error("reset command left list or output on");
    property p_fix;
        s_cmd(CMD_FIX) and s.running |=> !LIST_RUN_O && SETPOINT_O == $past(SETPOINT_O);
    endproperty
    a_fix: assert property (p_fix) else $error("fixed mode did not hold setpoint");
    property p_start;
        s_cmd(CMD_VLIST) and (!s.running && s.npts != '0 && !s.gen_seq) |=> LIST_RUN_O ##2 s.phase == PH_LOAD;
    endproperty
    a_start: assert property (p_start) else $error("list mode did not start playback");
    property p_forever;
        s_pass_end and (s.count == 8'h00) |=> LIST_RUN_O && s.phase == PH_SEQ && s.pos == $past(wrap_pos);
    endproperty
    a_forever: assert property (p_forever) else $error("endless list stopped");
    property p_count_end;
        s_pass_end and (s.count != 8'h00 && s.left == 8'h01) |=> !LIST_RUN_O && s.phase == PH_IDLE;
    endproperty
    a_count_end: assert property (p_count_end) else $error("counted list did not stop");
    property p_points;
        CE_I && RD_I && ADDR_I == REG_POINTS |=> RDATA_O == 32'($past(s.npts))
            ##1 RDATA_O == '0 || !$past(CE_I) || $past(RD_I);
    endproperty
    a_points: assert property (p_points) else $error("points readback wrong");
    property p_crlf;
        CE_I && WR_I && ADDR_I == REG_CHAR && WDATA_I[7:0] == CH_LF && s.prev_cr |=> $stable(s.msg_done) && !s.prev_cr;
    endproperty
    a_crlf: assert property (p_crlf) else $error("second terminator acted");
    property p_dwell_step;
        CE_I && s.phase == PH_DWELL && tick_end && s.dwell_left > VW'(1) && !WR_I |=>
            s.phase == PH_DWELL && s.dwell_left == VW'($past(s.dwell_left) - VW'(1));
    endproperty
    a_dwell_step: assert property (p_dwell_step) else $error("dwell did not count one tick");
endmodule
`default_nettype wire

/* File: rtl/wls_mem.sv */
// Single-port list memory with registered read data.
// Assumes writes and reads share one address; contents are never reset.
`timescale 1ns/1ps
`default_nettype none
module wls_mem #(
    parameter int DEPTH = 1002,
    parameter int AW = 10,
    parameter int DW = 16
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic ce_i,
    input wire logic we_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [DW-1:0] wdata_i,
    output logic [DW-1:0] rdata_o
);
    logic [DW-1:0] mem [0:DEPTH-1];

    // Contents survive any reset, only a clear of the length empties the list
    always_ff @(posedge CLK_I) begin
        if (ce_i && we_i) begin
            mem[addr_i] <= wdata_i;
        end
    end

    // Registered read, one cycle after the address
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= mem[addr_i];
        end
    end
endmodule
`default_nettype wire

/* File: rtl/wls_pkg.sv */
// Package for the waveform list sequencer: register map, command codes,
// character codes, timing constants and the state record of the core.
// Assumes a single 100 MHz clock and a 32-bit plain register port.
package wls_pkg;
    // Storage geometry
    localparam int MAX_PTS = 1002;
    localparam int AW = 10;
    localparam int CW = 11;
    localparam int VW = 16;
    localparam logic [CW-1:0] MAX_PTS_C = CW'(MAX_PTS);

    // Time base for dwell counting
    localparam int CLK_NS = 10;
    localparam int TICK_NS = 10000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYC - 1);

    // Register byte addresses
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_DATA = 8'h04;
    localparam logic [7:0] REG_COUNT = 8'h08;
    localparam logic [7:0] REG_SKIP = 8'h0C;
    localparam logic [7:0] REG_CFG = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_POINTS = 8'h18;
    localparam logic [7:0] REG_MEAS = 8'h1C;
    localparam logic [7:0] REG_CHAR = 8'h20;
    localparam logic [7:0] REG_SETPT = 8'h24;

    // Command codes written to REG_CMD
    localparam logic [3:0] CMD_LEVEL = 4'h0;
    localparam logic [3:0] CMD_ARM = 4'h1;
    localparam logic [3:0] CMD_TRG = 4'h2;
    localparam logic [3:0] CMD_RST = 4'h3;
    localparam logic [3:0] CMD_CLEAR = 4'h4;
    localparam logic [3:0] CMD_VLIST = 4'h5;
    localparam logic [3:0] CMD_CLIST = 4'h6;
    localparam logic [3:0] CMD_FIX = 4'h7;
    localparam logic [3:0] CMD_OUT_ON = 4'h8;
    localparam logic [3:0] CMD_OUT_OFF = 4'h9;
    localparam logic [3:0] CMD_FUNC_V = 4'hA;
    localparam logic [3:0] CMD_FUNC_C = 4'hB;
    localparam logic [3:0] CMD_ADD_V = 4'hC;
    localparam logic [3:0] CMD_ADD_C = 4'hD;
    localparam logic [3:0] CMD_ADD_DWELL = 4'hE;
    localparam logic [3:0] CMD_ADD_SEQ = 4'hF;

    // Field positions
    localparam int CFG_DIR = 0;
    localparam int CFG_GEN = 1;
    localparam int ST_RUN = 0;
    localparam int ST_ARMED = 1;
    localparam int ST_OUT = 2;
    localparam int ST_MCURR = 3;
    localparam int ST_KSET = 4;
    localparam int ST_KCURR = 5;
    localparam int ST_REJ = 6;
    localparam int ST_MSG = 7;
    localparam int ST_COMMON = 8;
    localparam int ST_DIR = 9;
    localparam int ST_GEN = 10;

    // Characters of the text front end
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_STAR = 8'h2A;
    localparam logic [7:0] CH_SEMI = 8'h3B;

    typedef enum logic [2:0] {PH_IDLE, PH_SEQ, PH_PT, PH_LOAD, PH_DWELL} wls_phase_e;

    typedef struct packed {
        wls_phase_e phase;
        logic [CW-1:0] pos;
        logic [CW-1:0] npts;
        logic [CW-1:0] nseq;
        logic [CW-1:0] ndwell;
        logic [CW-1:0] skip;
        logic [7:0] count;
        logic [7:0] left;
        logic [VW-1:0] data;
        logic [VW-1:0] setpoint;
        logic [VW-1:0] dwell_one;
        logic [VW-1:0] dwell_left;
        logic [15:0] tick_cnt;
        logic running;
        logic armed;
        logic trig;
        logic out_on;
        logic mode_curr;
        logic kind_set;
        logic kind_curr;
        logic dir_down;
        logic gen_seq;
        logic rejected;
        logic msg_done;
        logic msg_common;
        logic at_start;
        logic common_now;
        logic prev_cr;
        logic [31:0] rdata;
    } wls_state_s;
endpackage
